// >>> logic/rwc_defs.vh
`ifndef RWC_DEFS_VH
`define RWC_DEFS_VH

// I/O addresses
`define RWC_ADDR_WDCLR 8'h26
`define RWC_ADDR_PSC 8'hff
`define RWC_ADDR_USBADDR 8'h10
`define RWC_ADDR_IRQSTAT 8'hf8
`define RWC_ADDR_IRQMASK 8'hf9

// Status register bit positions
`define RWC_PSC_POR 4
`define RWC_PSC_BUS 5
`define RWC_PSC_WDT 6
`define RWC_PSC_SUSP 3

// Interrupt status bits
`define RWC_IRQ_POR 0
`define RWC_IRQ_BUS 1
`define RWC_IRQ_WDT 2

// Reset values
`define RWC_ZERO8 8'h00
`define RWC_RESET_PC 13'h0000
`define RWC_TXEN_BIT 7

// Timing, in nanoseconds and clock period
`define RWC_CLK_NS 5
`define RWC_TICK_BIT 11
`define RWC_SHORT_NS 128000
`define RWC_LONG_NS 96000000
`define RWC_WDHOLD_NS 2048000
`define RWC_CNT_W 25

`endif

// >>> logic/rwc_delay_timer.v
`include "rwc_defs.vh"

module rwc_delay_timer (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire [`RWC_CNT_W-1:0] load,
  output reg busy_r
);

  reg [`RWC_CNT_W-1:0] count_r;

  // ---------------------------------
  // Down counter, busy while nonzero
  // ---------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      count_r <= {`RWC_CNT_W{1'b0}};
      busy_r <= 1'b0;
    end else if (start) begin
      count_r <= load;
      busy_r <= 1'b1;
    end else if (count_r > {{(`RWC_CNT_W-1){1'b0}}, 1'b1}) begin
      count_r <= count_r - {{(`RWC_CNT_W-1){1'b0}}, 1'b1};
    end else begin
      count_r <= {`RWC_CNT_W{1'b0}};
      busy_r <= 1'b0;
    end
  end

endmodule

// >>> logic/rwc_reset_control.v
`include "rwc_defs.vh"

// How it works
// - Three reset sources: supply power-on, watchdog trip, USB bus reset.
// - Any reset zeroes USB address and clears transmit enable; interrupt mask is kept.
// - Any reset loads both stack pointers with zero.
// - Status register 0xff latches cause: bit4 power, bit5 bus, bit6 watchdog.
// - Power-on or watchdog reset starts at address zero, nothing pushed.
// - Power-on sets startup flag and forces ports to high-impedance input.
// - Strap high and idle bus at release enters suspend until bus activity.
// - Delay: strap high 128 us; else flag set 96 ms; else 128 us.
// - Two-bit watchdog advances on timer bit 11 tick.
// - Watchdog MSB rising trips reset and sets watchdog flag.
// - Any write to port 0x26 clears the watchdog counter.
// - No clear for 8.192 ms or more gives a watchdog reset.
// - Watchdog reset held 2.048 ms, then execution from address zero.
// - After watchdog reset transmitter off until address MSB set.
module rwc_reset_control #(
  parameter SHORT_CYC = (`RWC_SHORT_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS,
  parameter LONG_CYC = (`RWC_LONG_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS,
  parameter WDHOLD_CYC = (`RWC_WDHOLD_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS
) (
  input wire clk,
  input wire sys_rst,
  input wire supplyPowerOn,
  input wire usbBusReset,
  input wire strapP3b7,
  input wire usbDm,
  input wire usbDp,
  input wire [11:0] freeTimer,
  input wire [7:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWr,
  input wire ioRd,
  output reg [7:0] ioRdata_r,
  output reg cpuHold_r,
  output reg coreReset_r,
  output reg [12:0] resetPc_r,
  output reg pcLoad_r,
  output reg [7:0] callStackPtr_r,
  output reg [7:0] operandStackPtr_r,
  output reg [6:0] usbDevAddr_r,
  output reg usbTxEnable_r,
  output reg portsHighZ_r,
  output reg suspend_r,
  output reg irq_r
);

  localparam ST_RUN = 2'd0;
  localparam ST_WDHOLD = 2'd1;
  localparam ST_SUSPEND = 2'd2;
  localparam ST_DELAY = 2'd3;

  // ---------------------------------
  // Functions
  // ---------------------------------
  function [`RWC_CNT_W-1:0] cyc;
    input integer n;
    begin
      cyc = n[`RWC_CNT_W-1:0];
    end
  endfunction

  function wrHit;
    input [7:0] a;
    input [7:0] target;
    input we;
    begin
      wrHit = we && (a == target);
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] wdCount_r;
  reg tickPrev_r;
  reg busPrev_r;
  reg porFlag_r;
  reg busFlag_r;
  reg wdFlag_r;
  reg [2:0] irqStat_r;
  reg [2:0] irqMask_r;
  reg timerStart;
  reg [`RWC_CNT_W-1:0] timerLoad;
  wire timerBusy;

  wire tickRise = freeTimer[`RWC_TICK_BIT] && !tickPrev_r;
  wire busRise = usbBusReset && !busPrev_r;
  wire wdClear = wrHit(ioAddr, `RWC_ADDR_WDCLR, ioWr);
  wire pscWrite = wrHit(ioAddr, `RWC_ADDR_PSC, ioWr);
  wire [1:0] wdInc = wdCount_r + 2'd1;
  wire wdTrip = (state_r == ST_RUN) && tickRise && !wdClear && !wdCount_r[1] && wdInc[1];
  wire busIdle = usbDm && !usbDp;
  wire wake = usbBusReset || !usbDm || usbDp;
  wire anyReset = supplyPowerOn || wdTrip || busRise;
  wire [2:0] irqEvt = {wdTrip, busRise, supplyPowerOn};

  rwc_delay_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(timerStart),
    .load(timerLoad),
    .busy_r(timerBusy)
  );

  // ---------------------------------
  // Sequencer next state
  // ---------------------------------
  always @* begin
    state_nxt = state_r;
    timerStart = 1'b0;
    timerLoad = cyc(SHORT_CYC);
    case (state_r)
      ST_RUN: begin
        if (wdTrip) begin
          state_nxt = ST_WDHOLD;
          timerStart = 1'b1;
          timerLoad = cyc(WDHOLD_CYC);
        end
      end
      ST_WDHOLD: begin
        if (!timerBusy) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SUSPEND: begin
        if (wake) begin
          state_nxt = ST_DELAY;
          timerStart = 1'b1;
          timerLoad = cyc(SHORT_CYC);
        end
      end
      ST_DELAY: begin
        if (!timerBusy) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    // Start-up delay armed one cycle after power-on release
    if (relStart_r) begin
      state_nxt = ST_DELAY;
      timerStart = 1'b1;
      timerLoad = relLoad_r;
    end
    if (supplyPowerOn) begin
      state_nxt = ST_DELAY;
      timerStart = 1'b0;
    end
  end

  // ---------------------------------
  // Power-on release and sequencing
  // ---------------------------------
  reg porPrev_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_DELAY;
      porPrev_r <= 1'b1;
    end else begin
      porPrev_r <= supplyPowerOn;
      if (porPrev_r && !supplyPowerOn) begin
        if (strapP3b7 && busIdle) begin
          state_r <= ST_SUSPEND;
        end else begin
          state_r <= ST_DELAY;
        end
      end else begin
        state_r <= state_nxt;
      end
    end
  end

  // Startup delay select at power-on release
  wire relPor = porPrev_r && !supplyPowerOn && !(strapP3b7 && busIdle);
  wire [`RWC_CNT_W-1:0] startLoad = (!strapP3b7 && porFlag_r) ? cyc(LONG_CYC) : cyc(SHORT_CYC);
  reg relStart_r;
  reg [`RWC_CNT_W-1:0] relLoad_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      relStart_r <= 1'b0;
      relLoad_r <= {`RWC_CNT_W{1'b0}};
    end else begin
      relStart_r <= relPor;
      relLoad_r <= startLoad;
    end
  end

  // ---------------------------------
  // Watchdog counter
  // ---------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      wdCount_r <= 2'd0;
      tickPrev_r <= 1'b0;
      busPrev_r <= 1'b0;
    end else begin
      tickPrev_r <= freeTimer[`RWC_TICK_BIT];
      busPrev_r <= usbBusReset;
      if (anyReset || wdClear || state_r != ST_RUN) begin
        wdCount_r <= 2'd0;
      end else if (tickRise) begin
        wdCount_r <= wdInc;
      end
    end
  end

  // ---------------------------------
  // Cause flags, status register
  // ---------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      porFlag_r <= 1'b1;
      busFlag_r <= 1'b0;
      wdFlag_r <= 1'b0;
    end else begin
      if (supplyPowerOn) begin
        porFlag_r <= 1'b1;
      end else if (pscWrite) begin
        porFlag_r <= ioWdata[`RWC_PSC_POR];
      end
      if (busRise) begin
        busFlag_r <= 1'b1;
      end else if (pscWrite) begin
        busFlag_r <= ioWdata[`RWC_PSC_BUS];
      end
      if (wdTrip) begin
        wdFlag_r <= 1'b1;
      end else if (pscWrite) begin
        wdFlag_r <= ioWdata[`RWC_PSC_WDT];
      end
    end
  end

  // ---------------------------------
  // Interrupt status and mask
  // ---------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      irqStat_r <= 3'd0;
      irqMask_r <= 3'd0;
      irq_r <= 1'b0;
    end else begin
      if (wrHit(ioAddr, `RWC_ADDR_IRQSTAT, ioWr)) begin
        irqStat_r <= (irqStat_r & ~ioWdata[2:0]) | irqEvt;
      end else begin
        irqStat_r <= irqStat_r | irqEvt;
      end
      if (wrHit(ioAddr, `RWC_ADDR_IRQMASK, ioWr)) begin
        irqMask_r <= ioWdata[2:0];
      end
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  // ---------------------------------
  // Core reset outputs
  // ---------------------------------
  // Release edge itself held too, so entry to suspend never drops the hold
  wire relAny = porPrev_r && !supplyPowerOn;
  wire holdNow = supplyPowerOn || (state_nxt != ST_RUN) || relAny || relPor || relStart_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      cpuHold_r <= 1'b1;
      coreReset_r <= 1'b1;
      resetPc_r <= `RWC_RESET_PC;
      pcLoad_r <= 1'b0;
      callStackPtr_r <= `RWC_ZERO8;
      operandStackPtr_r <= `RWC_ZERO8;
      usbDevAddr_r <= 7'd0;
      usbTxEnable_r <= 1'b0;
      portsHighZ_r <= 1'b1;
      suspend_r <= 1'b0;
    end else begin
      cpuHold_r <= holdNow;
      coreReset_r <= anyReset || (state_r == ST_WDHOLD);
      suspend_r <= (state_nxt == ST_SUSPEND);
      pcLoad_r <= cpuHold_r && !holdNow;
      if (anyReset) begin
        callStackPtr_r <= `RWC_ZERO8;
        operandStackPtr_r <= `RWC_ZERO8;
        usbDevAddr_r <= 7'd0;
        usbTxEnable_r <= 1'b0;
      end else if (wrHit(ioAddr, `RWC_ADDR_USBADDR, ioWr)) begin
        usbDevAddr_r <= ioWdata[6:0];
        usbTxEnable_r <= ioWdata[`RWC_TXEN_BIT];
      end
      if (supplyPowerOn) begin
        portsHighZ_r <= 1'b1;
      end else if (!cpuHold_r) begin
        portsHighZ_r <= 1'b0;
      end
    end
  end

  // ---------------------------------
  // Read port
  // ---------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ioRdata_r <= `RWC_ZERO8;
    end else if (ioRd) begin
      case (ioAddr)
        `RWC_ADDR_PSC: ioRdata_r <= {1'b0, wdFlag_r, busFlag_r, porFlag_r, suspend_r, 3'd0};
        `RWC_ADDR_USBADDR: ioRdata_r <= {usbTxEnable_r, usbDevAddr_r};
        `RWC_ADDR_IRQSTAT: ioRdata_r <= {5'd0, irqStat_r};
        `RWC_ADDR_IRQMASK: ioRdata_r <= {5'd0, irqMask_r};
        default: ioRdata_r <= `RWC_ZERO8;
      endcase
    end else begin
      ioRdata_r <= `RWC_ZERO8;
    end
  end

endmodule

// >>> verif/rwc_reset_control_bench.sv
module rwc_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHORT = 20;
  localparam int LONG = 50;
  localparam int WDH = 30;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supplyPowerOn = 1'b1;
  logic strapP3b7 = 1'b0;
  logic wakeK = 1'b0;
  logic busRst = 1'b0;
  logic [11:0] freeTimer = 12'h000;
  logic [7:0] ioAddr = 8'h00;
  logic [7:0] ioWdata = 8'h00;
  logic ioWr = 1'b0;
  logic ioRd = 1'b0;
  logic rdSeen = 1'b0;
  wire usbDm, usbDp, usbBusReset;
  wire [7:0] ioRdata_r, callStackPtr_r, operandStackPtr_r;
  wire [12:0] resetPc_r;
  wire [6:0] usbDevAddr_r;
  wire cpuHold_r, coreReset_r, pcLoad_r, usbTxEnable_r, portsHighZ_r, suspend_r, irq_r;
  logic [7:0] expQ[$];
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  integer seed = 32'ha8e8eaef;
  always #2.5 clk = ~clk;
  rwc_reset_control #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .WDHOLD_CYC(WDH)) DUT (.*);
  rwc_usb_line_model LINES (.clk(clk), .wakeK(wakeK), .busRst(busRst), .usbDm(usbDm), .usbDp(usbDp),
    .usbBusReset(usbBusReset));
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ioAddr <= a;
    ioWdata <= d;
    ioWr <= 1'b1;
    @(posedge clk);
    ioWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    ioAddr <= a;
    ioRd <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    ioRd <= 1'b0;
  endtask
  task automatic tick;
    @(posedge clk);
    freeTimer <= {1'b1, 11'($random(seed))};
    repeat (3) @(posedge clk);
    freeTimer <= 12'h000;
    repeat (2) @(posedge clk);
  endtask
  // Cycles until the restart pulse, bounded
  task automatic hold(input int lo);
    n = 0;
    while (pcLoad_r !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 1000) begin
        mismatches++;
        end_of_test;
      end
    end
    chk(8'(n + 2 >= lo && n <= lo + 8), 8'h01);
  endtask
  // Read data checked the cycle after the strobe
  always @(posedge clk) rdSeen <= ioRd;
  always @(negedge clk) begin
    if (rdSeen) begin
      chk(ioRdata_r, expQ.pop_front());
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(portsHighZ_r), 8'h01);
    @(posedge clk);
    supplyPowerOn <= 1'b0;
    hold(LONG);
    chk(callStackPtr_r | operandStackPtr_r, 8'h00);
    chk(8'(|resetPc_r), 8'h00);
    rd(8'hff, 8'h10);
    rd(8'h55, 8'h00);
    rd(8'hf9, 8'h00);
    wr(8'h10, 8'h85);
    rd(8'h10, 8'h85);
    wr(8'hff, 8'h00);
    tick;
    wr(8'h26, 8'($random(seed)));
    tick;
    @(negedge clk);
    chk(8'(coreReset_r), 8'h00);
    tick;
    hold(WDH - 6);
    rd(8'hff, 8'h40);
    rd(8'h10, 8'h00);
    wr(8'h10, 8'h85);
    wr(8'hff, 8'h00);
    busRst <= 1'b1;
    repeat (3) @(posedge clk);
    busRst <= 1'b0;
    repeat (4) @(negedge clk);
    chk(8'({irq_r, cpuHold_r}), 8'h00);
    rd(8'hff, 8'h20);
    rd(8'h10, 8'h00);
    wr(8'hf9, 8'h02);
    repeat (2) @(negedge clk);
    chk(8'(irq_r), 8'h01);
    wr(8'hf9, 8'h00);
    repeat (2) @(negedge clk);
    chk(8'(irq_r), 8'h00);
    wr(8'hf9, 8'h02);
    wr(8'hf8, 8'h02);
    repeat (2) @(negedge clk);
    chk(8'(irq_r), 8'h00);
    wr(8'hff, 8'h00);
    strapP3b7 <= 1'b1;
    supplyPowerOn <= 1'b1;
    repeat (3) @(posedge clk);
    supplyPowerOn <= 1'b0;
    repeat (5) @(negedge clk);
    chk(8'(suspend_r), 8'h01);
    rd(8'hff, 8'h18);
    wakeK <= 1'b1;
    hold(SHORT);
    end_of_test;
  end
endmodule

bind rwc_reset_control rwc_reset_control_monitor MON (.*);

// >>> verif/rwc_reset_control_monitor.sv
module rwc_reset_control_monitor (
  input wire clk,
  input wire sys_rst,
  input wire supplyPowerOn,
  input wire [11:0] freeTimer,
  input wire [7:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWr,
  input wire cpuHold_r,
  input wire coreReset_r,
  input wire [12:0] resetPc_r,
  input wire pcLoad_r,
  input wire [7:0] callStackPtr_r,
  input wire [7:0] operandStackPtr_r,
  input wire [6:0] usbDevAddr_r,
  input wire usbTxEnable_r,
  input wire portsHighZ_r,
  input wire suspend_r,
  input wire irq_r
);
  logic [1:0] tickCnt_r;
  logic tickPrev_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------
  // Ticks since last clear or reset
  // ------
  always @(posedge clk) begin
    tickPrev_r <= freeTimer[11];
    if (sys_rst || coreReset_r || (ioWr && ioAddr == 8'h26)) begin
      tickCnt_r <= 2'h0;
    end else if (freeTimer[11] && !tickPrev_r && tickCnt_r != 2'h3) begin
      tickCnt_r <= tickCnt_r + 2'h1;
    end
  end
  wd_trip_a: assert property (tickCnt_r[1] |-> ##[0:4] coreReset_r) else $error("no trip");
  wd_hold_a: assert property ($rose(coreReset_r) && tickCnt_r[1] |-> coreReset_r[*8]) else $error("short hold");
  sp_zero_a: assert property (coreReset_r |=> callStackPtr_r == 8'h00 && operandStackPtr_r == 8'h00) else $error("sp");
  addr_clr_a: assert property ($fell(coreReset_r) |-> usbDevAddr_r == 7'h00 && !usbTxEnable_r) else $error("addr");
  pc_zero_a: assert property (pcLoad_r |-> resetPc_r == 13'h0000 && !suspend_r) else $error("pc");
  hz_a: assert property (supplyPowerOn |=> portsHighZ_r) else $error("ports");
  susp_hold_a: assert property (suspend_r |-> cpuHold_r) else $error("suspend");
  irq_mask_a: assert property (ioWr && ioAddr == 8'hf9 && ioWdata == 8'h00 |-> ##2 !irq_r) else $error("irq");
  cover property (suspend_r);
  cover property (tickCnt_r[1]);
  cover property (irq_r);
endmodule

// >>> verif/rwc_usb_line_model.sv
module rwc_usb_line_model (
  input wire clk,
  input wire wakeK,
  input wire busRst,
  output logic usbDm = 1'b1,
  output logic usbDp = 1'b0,
  output logic usbBusReset = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle J keeps minus high; K resume swaps the lines
  always @(posedge clk) begin
    usbDm <= !wakeK;
    usbDp <= wakeK;
    usbBusReset <= busRst;
  end
endmodule
